// File: design/sclk_edge_sync.sv
/*
   Two-flop synchroniser with rising edge detect for a free-running oscillator input.
   Assumes the oscillator is well below half the reference clock rate.
*/
`timescale 1ns/1ps
module sclk_edge_sync
(
   input  wire logic ref_clk_in,
   input  wire logic rst_in,
   input  wire logic raw_in,
   output logic      rise_out
);

   logic meta_reg;
   logic sync_reg;
   logic prev_reg;

   // Synchroniser chain; only the second and third stages are looked at
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= raw_in;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // One pulse per oscillator rising edge
   assign rise_out = sync_reg & ~prev_reg;

endmodule // sclk_edge_sync

// File: design/sclk_wake_ctrl.sv
/*
   System clock selection and halt / wake-up sequencing. Produces a system clock
   tick, CPU run enable and oscillator enables from the mode control and oscillator configuration registers.
   Assumes oscillator inputs are asynchronous square waves, halt and wake are
   one-cycle pulses from logic on the reference clock.
*/
`timescale 1ns/1ps

// Summary of operation
// - Halt with idle select set enters an idle state.
// - Halt with idle select clear enters a sleep state.
// - Clocked idle stops the CPU but keeps system clock ticking.
// - Unclocked idle stops both CPU and system clock.
// - Select high gives undivided high clock; low gives divided or low clock.
// - Divider field: 000/001 low, 010 /64, 011 /32, 100 /16, 101 /4, 111 /2.
// - Selecting the low clock turns the high oscillator off.
// - Fast wake uses sub clock, only from sub-clock sleep or unclocked idle.
// - Wake from full stop sleep ignores fast wake enable.
// - Fast wake: 1-2 sub cycles, sub clock until 1024 crystal cycles, flag, switch.
// - RC high oscillators wake in 15-16 cycles; low internal RC in 1-2.
// - With RC oscillators the fast wake enable has no effect.
// - Fast wake enable is a bit of the system mode control register.
// - Fast wake enable applies only with the high crystal oscillator.
module sclk_wake_ctrl
(
   input  wire logic       ref_clk_in,
   input  wire logic       rst_in,
   input  wire logic       high_osc_in,
   input  wire logic       low_osc_in,
   input  wire logic       halt_in,
   input  wire logic       wake_in,
   input  wire logic [3:0] addr_in,
   input  wire logic [7:0] wr_data_in,
   input  wire logic       wr_en_in,
   input  wire logic       rd_en_in,
   output logic [7:0]      rd_data_out,
   output logic            sys_tick_out,
   output logic            cpu_run_out,
   output logic            high_osc_en_out,
   output logic            sub_osc_en_out,
   output logic            sys_on_low_out
);

   logic [7:0]             mode_reg;
   logic [7:0]             cfg_reg;
   logic [7:0]             rd_data_reg;
   sclk_pkg::sclk_state_t  state_reg;
   sclk_pkg::sclk_state_t  halt_target;
   sclk_pkg::sclk_wake_t   kind_reg;
   sclk_pkg::sclk_wake_t   wake_kind_next;
   logic [10:0]            cnt_reg;
   logic [10:0]            wake_tgt;
   logic [10:0]            stab_tgt;
   logic [5:0]             div_cnt_reg;
   logic                   hrdy_reg;
   logic                   lto_reg;
   logic                   high_edge;
   logic                   low_edge;
   logic                   src_edge;
   logic                   sys_on_low;
   logic                   div_hit;
   logic                   tick_next;
   logic                   sys_tick_reg;
   logic                   cpu_run_reg;
   logic                   high_en_reg;
   logic                   sub_en_reg;
   logic                   sys_low_reg;
   logic [1:0]             osc_type;
   logic [2:0]             div_sel;
   logic                   hl_sel;
   logic                   idle_select;
   logic                   fast_wake_enable;

   // Oscillator edge detectors
   sclk_edge_sync u_high_sync
   (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .raw_in     (high_osc_in),
      .rise_out   (high_edge)
   );

   sclk_edge_sync u_low_sync
   (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .raw_in     (low_osc_in),
      .rise_out   (low_edge)
   );

   // True when the select and divider fields pick the low clock
   function automatic logic uses_low(input logic hl, input logic [2:0] dv);
      uses_low = !hl && (dv == sclk_pkg::DIV_LOW_A || dv == sclk_pkg::DIV_LOW_B);
   endfunction

   // Terminal mask of the high clock divider
   function automatic logic [5:0] div_mask(input logic [2:0] dv);
      if (dv == sclk_pkg::DIV_H64)
         div_mask = sclk_pkg::MASK_H64;
      else if (dv == sclk_pkg::DIV_H32)
         div_mask = sclk_pkg::MASK_H32;
      else if (dv == sclk_pkg::DIV_H16)
         div_mask = sclk_pkg::MASK_H16;
      else if (dv == sclk_pkg::DIV_H4)
         div_mask = sclk_pkg::MASK_H4;
      else
         div_mask = sclk_pkg::MASK_H2;
   endfunction

   // Register fields
   assign hl_sel           = mode_reg[sclk_pkg::HLSEL_BIT];
   assign idle_select      = mode_reg[sclk_pkg::IDLE_BIT];
   assign fast_wake_enable = mode_reg[sclk_pkg::FAST_BIT];
   assign div_sel          = mode_reg[sclk_pkg::DIV_LSB +: 3];
   assign osc_type         = cfg_reg[sclk_pkg::OSC_TYPE_LSB +: 2];
   assign sys_on_low       = uses_low(hl_sel, div_sel) || osc_type == sclk_pkg::OSC_LOWRC;
   assign stab_tgt         = (osc_type == sclk_pkg::OSC_XTAL) ? sclk_pkg::XTAL_STAB_CYC
                                                               : sclk_pkg::RC_WAKE_CYC;

   // Register writes; status bits are not writable
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         mode_reg <= sclk_pkg::MODE_RESET;
         cfg_reg  <= sclk_pkg::CFG_RESET;
      end
      else if (wr_en_in)
      begin
         if (addr_in == sclk_pkg::MODE_ADDR)
            mode_reg <= wr_data_in & sclk_pkg::MODE_WR_MASK;
         else if (addr_in == sclk_pkg::OSC_CFG_ADDR)
            cfg_reg <= wr_data_in & sclk_pkg::CFG_WR_MASK;
      end
   end

   // Read data, valid only in the cycle after the read strobe
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
         rd_data_reg <= 8'h00;
      else if (rd_en_in && addr_in == sclk_pkg::MODE_ADDR)
         rd_data_reg <= mode_reg | ({7'h00, hrdy_reg} << sclk_pkg::HRDY_BIT)
                                 | ({7'h00, lto_reg} << sclk_pkg::LTO_BIT);
      else if (rd_en_in && addr_in == sclk_pkg::OSC_CFG_ADDR)
         rd_data_reg <= cfg_reg;
      else
         rd_data_reg <= 8'h00;
   end

   // Stop state chosen by a halt command
   always_comb
   begin
      if (idle_select)
         halt_target = cfg_reg[sclk_pkg::KEEP_BIT] ? sclk_pkg::ST_IDLE_CLK : sclk_pkg::ST_IDLE_NOCLK;
      else
         halt_target = cfg_reg[sclk_pkg::SUB_ON_BIT] ? sclk_pkg::ST_SLEEP_SUB : sclk_pkg::ST_SLEEP_STOP;
   end

   // Wake sequence chosen by stop state, oscillator type and fast wake enable
   always_comb
   begin
      if (state_reg == sclk_pkg::ST_IDLE_CLK)
         wake_kind_next = sys_on_low ? sclk_pkg::WK_LOW1 : sclk_pkg::WK_HIGH1;
      else if (sys_on_low)
         wake_kind_next = sclk_pkg::WK_LOW1;
      else if (osc_type != sclk_pkg::OSC_XTAL)
         wake_kind_next = sclk_pkg::WK_HSTAB;
      else if (fast_wake_enable && state_reg != sclk_pkg::ST_SLEEP_STOP)
         wake_kind_next = sclk_pkg::WK_FAST;
      else
         wake_kind_next = sclk_pkg::WK_HSTAB;
   end

   // Count target and counted source of the current wake sequence
   assign wake_tgt = (kind_reg == sclk_pkg::WK_HSTAB) ? stab_tgt : sclk_pkg::QUICK_CYC;
   assign src_edge = (kind_reg == sclk_pkg::WK_LOW1 || kind_reg == sclk_pkg::WK_FAST) ? low_edge
                                                                                       : high_edge;

   // Operating state, wake counter and high oscillator ready flag
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_reg <= sclk_pkg::ST_WAKE;
         kind_reg  <= sclk_pkg::WK_HSTAB;
         cnt_reg   <= 11'h000;
         hrdy_reg  <= 1'b0;
      end
      else
      begin
         case (state_reg)
            sclk_pkg::ST_RUN:
            begin
               if (halt_in)
               begin
                  state_reg <= halt_target;
                  cnt_reg   <= 11'h000;
                  if (halt_target != sclk_pkg::ST_IDLE_CLK || sys_on_low)
                     hrdy_reg <= 1'b0;
               end
               else if (sys_on_low)
               begin
                  hrdy_reg <= 1'b0;
                  cnt_reg <= 11'h000;
               end
               else if (!hrdy_reg && high_edge)
               begin
                  if (cnt_reg == stab_tgt - 11'h001)
                  begin
                     hrdy_reg <= 1'b1;
                     cnt_reg  <= 11'h000;
                  end
                  else
                     cnt_reg <= cnt_reg + 11'h001;
               end
            end
            sclk_pkg::ST_IDLE_CLK, sclk_pkg::ST_IDLE_NOCLK,
            sclk_pkg::ST_SLEEP_SUB, sclk_pkg::ST_SLEEP_STOP:
            begin
               if (wake_in)
               begin
                  state_reg <= sclk_pkg::ST_WAKE;
                  kind_reg  <= wake_kind_next;
                  cnt_reg   <= 11'h000;
               end
            end
            sclk_pkg::ST_WAKE:
            begin
               if (src_edge)
               begin
                  if (cnt_reg == wake_tgt - 11'h001)
                  begin
                     cnt_reg <= 11'h000;
                     if (kind_reg == sclk_pkg::WK_FAST)
                        state_reg <= sclk_pkg::ST_FAST;
                     else
                     begin
                        state_reg <= sclk_pkg::ST_RUN;
                        if (kind_reg == sclk_pkg::WK_HSTAB)
                           hrdy_reg <= 1'b1;
                     end
                  end
                  else
                     cnt_reg <= cnt_reg + 11'h001;
               end
            end
            sclk_pkg::ST_FAST:
            begin
               if (high_edge)
               begin
                  if (cnt_reg == sclk_pkg::XTAL_STAB_CYC - 11'h001)
                  begin
                     hrdy_reg  <= 1'b1;
                     cnt_reg   <= 11'h000;
                     state_reg <= sclk_pkg::ST_RUN;
                  end
                  else
                     cnt_reg <= cnt_reg + 11'h001;
               end
            end
            default:
               state_reg <= sclk_pkg::ST_RUN;
         endcase
      end
   end

   // Low oscillator ready flag: dropped in full stop sleep, set on first low edge
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
         lto_reg <= 1'b0;
      else if (state_reg == sclk_pkg::ST_SLEEP_STOP)
         lto_reg <= 1'b0;
      else if (low_edge)
         lto_reg <= 1'b1;
   end

   // High clock divider counter
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
         div_cnt_reg <= 6'h00;
      else if (high_edge)
         div_cnt_reg <= div_cnt_reg + 6'h01;
   end

   assign div_hit = (div_cnt_reg & div_mask(div_sel)) == div_mask(div_sel);

   // System clock tick selection
   always_comb
   begin
      tick_next = 1'b0;
      if (state_reg == sclk_pkg::ST_RUN || state_reg == sclk_pkg::ST_IDLE_CLK)
      begin
         if (sys_on_low || !hrdy_reg)
            tick_next = low_edge;
         else if (hl_sel)
            tick_next = high_edge;
         else
            tick_next = high_edge && div_hit;
      end
      else if (state_reg == sclk_pkg::ST_FAST)
         tick_next = low_edge;
   end

   // Registered outputs
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         sys_tick_reg <= 1'b0;
         cpu_run_reg  <= 1'b0;
         high_en_reg  <= 1'b1;
         sub_en_reg   <= 1'b1;
         sys_low_reg  <= 1'b0;
      end
      else
      begin
         sys_tick_reg <= tick_next;
         cpu_run_reg  <= state_reg == sclk_pkg::ST_RUN || state_reg == sclk_pkg::ST_FAST;
         high_en_reg  <= osc_type != sclk_pkg::OSC_LOWRC &&
                         (((state_reg == sclk_pkg::ST_RUN || state_reg == sclk_pkg::ST_IDLE_CLK)
                           && !sys_on_low)
                          || state_reg == sclk_pkg::ST_FAST
                          || (state_reg == sclk_pkg::ST_WAKE && kind_reg != sclk_pkg::WK_LOW1));
         sub_en_reg   <= state_reg != sclk_pkg::ST_SLEEP_STOP;
         sys_low_reg  <= sys_on_low || state_reg == sclk_pkg::ST_FAST;
      end
   end

   assign rd_data_out     = rd_data_reg;
   assign sys_tick_out    = sys_tick_reg;
   assign cpu_run_out     = cpu_run_reg;
   assign high_osc_en_out = high_en_reg;
   assign sub_osc_en_out  = sub_en_reg;
   assign sys_on_low_out  = sys_low_reg;

   // Checks
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);

   a_halt_to_idle: assert property (state_reg == sclk_pkg::ST_RUN && halt_in && idle_select |=>
      (state_reg == sclk_pkg::ST_IDLE_CLK || state_reg == sclk_pkg::ST_IDLE_NOCLK))
      else $error("halt with idle select did not enter idle");
   a_halt_to_sleep: assert property (state_reg == sclk_pkg::ST_RUN && halt_in && !idle_select |=>
      (state_reg == sclk_pkg::ST_SLEEP_SUB || state_reg == sclk_pkg::ST_SLEEP_STOP))
      else $error("halt without idle select did not enter sleep");
   a_idle_keeps_tick: assert property (state_reg == sclk_pkg::ST_IDLE_CLK && sys_on_low && low_edge
      |=> sys_tick_out && !cpu_run_out)
      else $error("clocked idle lost the system tick");
   a_idle_stops_all: assert property (state_reg == sclk_pkg::ST_IDLE_NOCLK [*2]
      |-> !sys_tick_out && !cpu_run_out)
      else $error("unclocked idle still ticking");
   a_full_rate_tick: assert property (state_reg == sclk_pkg::ST_RUN && hl_sel && hrdy_reg
      && !sys_on_low && high_edge |=> sys_tick_out)
      else $error("full rate tick missing");
   a_low_select_tick: assert property (state_reg == sclk_pkg::ST_RUN && !hl_sel && div_sel == 3'h0
      && low_edge |=> sys_tick_out)
      else $error("low clock tick missing");
   a_high_off_on_low: assert property (state_reg == sclk_pkg::ST_RUN && sys_on_low
      |=> !high_osc_en_out && !hrdy_reg)
      else $error("high oscillator left running on low clock");
   a_stop_no_fast: assert property (state_reg == sclk_pkg::ST_SLEEP_STOP && wake_in
      |=> kind_reg != sclk_pkg::WK_FAST)
      else $error("fast wake used from full stop sleep");
   a_fast_switch: assert property (state_reg == sclk_pkg::ST_FAST && high_edge
      && cnt_reg == 11'h3ff |=> state_reg == sclk_pkg::ST_RUN && hrdy_reg)
      else $error("fast wake did not switch after crystal count");
   a_fast_first_sub: assert property (state_reg == sclk_pkg::ST_WAKE && kind_reg == sclk_pkg::WK_FAST
      && low_edge |=> state_reg == sclk_pkg::ST_FAST ##1 cpu_run_out)
      else $error("fast wake not running after first sub edge");
   a_rc_wake_count: assert property (state_reg == sclk_pkg::ST_WAKE && kind_reg == sclk_pkg::WK_HSTAB
      && osc_type != sclk_pkg::OSC_XTAL && high_edge && cnt_reg == 11'h00e |=> state_reg == sclk_pkg::ST_RUN)
      else $error("rc wake count wrong");
   a_rc_ignores_fast: assert property (state_reg != sclk_pkg::ST_RUN && state_reg != sclk_pkg::ST_WAKE
      && state_reg != sclk_pkg::ST_FAST && wake_in && osc_type != sclk_pkg::OSC_XTAL
      |=> kind_reg != sclk_pkg::WK_FAST)
      else $error("fast wake used with rc oscillator");
   a_idle_quick_wake: assert property (state_reg == sclk_pkg::ST_IDLE_CLK && wake_in
      |=> kind_reg == sclk_pkg::WK_HIGH1 || kind_reg == sclk_pkg::WK_LOW1)
      else $error("clocked idle wake not quick");

   c_fast_wake: cover property (state_reg == sclk_pkg::ST_FAST ##1 state_reg == sclk_pkg::ST_RUN);
   c_idle_wake: cover property (state_reg == sclk_pkg::ST_IDLE_CLK ##1 state_reg == sclk_pkg::ST_WAKE);
   c_sleep_stop: cover property (state_reg == sclk_pkg::ST_SLEEP_STOP && wake_in);

endmodule // sclk_wake_ctrl

// File: include/sclk_pkg.sv
/*
   Shared constants and types for the system clock select and wake-up controller:
   register offsets, field positions, reset values, oscillator codes and wake counts.
   Assumes it is compiled before every design file that names it.
*/
package sclk_pkg;

   // Register offsets on the plain register port
   localparam logic [3:0] MODE_ADDR     = 4'h0;
   localparam logic [3:0] OSC_CFG_ADDR  = 4'h1;

   // System mode control fields
   localparam int          HLSEL_BIT     = 0;
   localparam int          IDLE_BIT      = 1;
   localparam int          HRDY_BIT      = 2;
   localparam int          LTO_BIT       = 3;
   localparam int          FAST_BIT      = 4;
   localparam int          DIV_LSB       = 5;
   localparam logic [7:0]  MODE_RESET    = 8'h03;
   localparam logic [7:0]  MODE_WR_MASK  = 8'hf3;

   // Oscillator configuration fields
   localparam int          OSC_TYPE_LSB  = 0;
   localparam int          KEEP_BIT      = 2;
   localparam int          SUB_ON_BIT    = 3;
   localparam logic [7:0]  CFG_RESET     = 8'h00;
   localparam logic [7:0]  CFG_WR_MASK   = 8'h0f;

   // System oscillator type codes
   localparam logic [1:0]  OSC_XTAL      = 2'h0;
   localparam logic [1:0]  OSC_EXTRC     = 2'h1;
   localparam logic [1:0]  OSC_INTRC     = 2'h2;
   localparam logic [1:0]  OSC_LOWRC     = 2'h3;

   // Divider field codes
   localparam logic [2:0]  DIV_LOW_A     = 3'h0;
   localparam logic [2:0]  DIV_LOW_B     = 3'h1;
   localparam logic [2:0]  DIV_H64       = 3'h2;
   localparam logic [2:0]  DIV_H32       = 3'h3;
   localparam logic [2:0]  DIV_H16       = 3'h4;
   localparam logic [2:0]  DIV_H4        = 3'h5;

   // Divider terminal masks on the high clock edge counter
   localparam logic [5:0]  MASK_H64      = 6'h3f;
   localparam logic [5:0]  MASK_H32      = 6'h1f;
   localparam logic [5:0]  MASK_H16      = 6'h0f;
   localparam logic [5:0]  MASK_H4       = 6'h03;
   localparam logic [5:0]  MASK_H2       = 6'h01;

   // Wake and stabilisation counts, in oscillator cycles
   localparam logic [10:0] XTAL_STAB_CYC = 11'h400;
   localparam logic [10:0] RC_WAKE_CYC   = 11'h00f;
   localparam logic [10:0] QUICK_CYC     = 11'h001;

   typedef enum logic [2:0] {
      ST_RUN,
      ST_IDLE_CLK,
      ST_IDLE_NOCLK,
      ST_SLEEP_SUB,
      ST_SLEEP_STOP,
      ST_WAKE,
      ST_FAST
   } sclk_state_t;

   typedef enum logic [1:0] {
      WK_HIGH1,
      WK_LOW1,
      WK_HSTAB,
      WK_FAST
   } sclk_wake_t;

endpackage

// File: tb/testbench.sv
/*
   Self-checking bench for the system clock select and wake-up controller.
   Assumes the oscillator inputs are made here, well below the reference clock rate.
*/
`timescale 1ns/1ps
module testbench;
   logic       ref_clk_in = 1'b0;
   logic       rst_in     = 1'b1;
   logic       high_osc_in = 1'b0;
   logic       low_osc_in = 1'b0;
   logic       halt_in = 1'b0;
   logic       wake_in = 1'b0;
   logic [3:0] addr_in = 4'h0;
   logic [7:0] wr_data_in = 8'h00;
   logic       wr_en_in = 1'b0;
   logic       rd_en_in = 1'b0;
   logic [7:0] rd_data_out;
   logic       sys_tick_out, cpu_run_out, high_osc_en_out, sub_osc_en_out, sys_on_low_out;
   int         err_total = 0;
   int         total_checks = 0;
   int         cyc = 0;
   int         ticks = 0;
   int         hcnt = 0;
   int         lcnt = 0;
   logic [7:0] v;
   int         n;

   sclk_wake_ctrl u_sclk_wake_ctrl (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .high_osc_in(high_osc_in),
      .low_osc_in(low_osc_in), .halt_in(halt_in), .wake_in(wake_in), .addr_in(addr_in),
      .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
      .sys_tick_out(sys_tick_out), .cpu_run_out(cpu_run_out), .high_osc_en_out(high_osc_en_out),
      .sub_osc_en_out(sub_osc_en_out), .sys_on_low_out(sys_on_low_out));

   // Reference clock, 25 ns period
   always #12.5 ref_clk_in = ~ref_clk_in;

   // High oscillator period 8 cycles, low oscillator 40 cycles; tick counter; hang guard
   always @(posedge ref_clk_in)
   begin
      hcnt <= (hcnt == 3) ? 0 : hcnt + 1;
      lcnt <= (lcnt == 19) ? 0 : lcnt + 1;
      if (hcnt == 3) high_osc_in <= ~high_osc_in;
      if (lcnt == 19) low_osc_in <= ~low_osc_in;
      if (sys_tick_out === 1'b1) ticks <= ticks + 1;
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         err_total = err_total + 1;
         final_report();
      end
   end

   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_rng(input string what, input int lo, input int hi, input int got);
      total_checks++;
      if (got < lo || got > hi)
      begin
         err_total++;
         $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      wr_en_in <= 1'b1; addr_in <= a; wr_data_in <= d;
      @(posedge ref_clk_in);
      wr_en_in <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk_in);
      rd_en_in <= 1'b1; addr_in <= a;
      @(posedge ref_clk_in);
      rd_en_in <= 1'b0;
      #1 d = rd_data_out;
   endtask

   task automatic pulse(input bit is_wake);
      @(posedge ref_clk_in);
      if (is_wake) wake_in <= 1'b1; else halt_in <= 1'b1;
      @(posedge ref_clk_in);
      wake_in <= 1'b0; halt_in <= 1'b0;
   endtask

   // Cycles until the CPU runs again, bounded
   task automatic wait_run(input int lim, output int c);
      c = 0;
      while (cpu_run_out !== 1'b1 && c < lim)
      begin
         @(posedge ref_clk_in);
         c++;
      end
   endtask

   task automatic t_reset_regs();
      repeat (2) @(posedge ref_clk_in);
      chk8("cpu_run in reset", 8'h00, {7'h0, cpu_run_out});
      chk8("osc enables in reset", 8'h03, {6'h0, high_osc_en_out, sub_osc_en_out});
      repeat (10) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      wait_run(9000, n);
      chk_rng("power-on stabilisation", 8150, 8230, n);
      rd(4'h0, v); chk8("mode reg", 8'h0f, v);
      rd(4'h1, v); chk8("cfg reg", 8'h00, v);
      wr(4'h5, 8'hff); rd(4'h5, v); chk8("unmapped", 8'h00, v);
      wr(4'h0, 8'h13); rd(4'h0, v); chk8("fast enable bit", 8'h1f, v);
      $display("test reset_regs done");
   endtask

   task automatic t_clocked_idle();
      wr(4'h1, 8'h04); wr(4'h0, 8'h03);
      pulse(0); repeat (3) @(posedge ref_clk_in);
      chk8("cpu halted", 8'h00, {7'h0, cpu_run_out});
      n = ticks; repeat (100) @(posedge ref_clk_in);
      chk_rng("ticks in clocked idle", 11, 14, ticks - n);
      pulse(1); wait_run(300, n);
      chk_rng("clocked idle wake", 1, 22, n);
      $display("test clocked_idle done");
   endtask

   task automatic t_unclocked_idle();
      wr(4'h1, 8'h02); wr(4'h0, 8'h13);
      pulse(0); repeat (3) @(posedge ref_clk_in);
      n = ticks; repeat (100) @(posedge ref_clk_in);
      chk_rng("ticks in unclocked idle", 0, 0, ticks - n);
      chk8("cpu halted", 8'h00, {7'h0, cpu_run_out});
      pulse(1); wait_run(300, n);
      chk_rng("rc wake with fast enable", 110, 136, n);
      $display("test unclocked_idle done");
   endtask

   task automatic t_full_stop();
      wr(4'h1, 8'h00); wr(4'h0, 8'h11);
      pulse(0); repeat (3) @(posedge ref_clk_in);
      chk8("sub osc off in stop", 8'h00, {7'h0, sub_osc_en_out});
      pulse(1); wait_run(9000, n);
      chk_rng("stop sleep ignores fast", 8150, 8230, n);
      $display("test full_stop done");
   endtask

   task automatic t_fast_wake();
      wr(4'h1, 8'h08); wr(4'h0, 8'h11);
      pulse(0); repeat (3) @(posedge ref_clk_in);
      chk8("sub osc kept", 8'h01, {7'h0, sub_osc_en_out});
      pulse(1); wait_run(300, n);
      chk_rng("fast wake", 1, 90, n);
      rd(4'h0, v); chk8("ready flag low on sub", 8'h00, {7'h0, v[2]});
      chk8("running on sub", 8'h01, {7'h0, sys_on_low_out});
      n = 0;
      while (sys_on_low_out !== 1'b0 && n < 9000)
      begin
         @(posedge ref_clk_in);
         n++;
      end
      chk_rng("switch to crystal", 7900, 8230, n);
      rd(4'h0, v); chk8("ready flag set", 8'h01, {7'h0, v[2]});
      $display("test fast_wake done");
   endtask

   task automatic t_divider();
      logic [2:0] codes [7] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h7, 3'h0, 3'h1};
      int         exp   [7] = '{4, 8, 16, 64, 128, 51, 51};
      wr(4'h0, 8'h01); n = ticks; repeat (2048) @(posedge ref_clk_in);
      chk_rng("undivided ticks", 255, 257, ticks - n);
      for (int i = 0; i < 7; i++)
      begin
         wr(4'h0, {codes[i], 5'h00}); repeat (100) @(posedge ref_clk_in);
         n = ticks; repeat (2048) @(posedge ref_clk_in);
         chk_rng("divided ticks", exp[i] - 1, exp[i] + 1, ticks - n);
      end
      chk8("high osc off on low", 8'h01, {6'h0, high_osc_en_out, sys_on_low_out});
      $display("test divider done");
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial
   begin
      #1;
      t_reset_regs();
      t_clocked_idle();
      t_unclocked_idle();
      t_full_stop();
      t_fast_wake();
      t_divider();
      final_report();
   end
endmodule // testbench
